// *** tb/vpdsr_access_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vpdsr_cfg.svh"
// ****************************************
// product data access bench
// ****************************************
module vpdsr_access_test;
  typedef struct packed {
    logic [8:0] a;
    logic wr;
    logic [31:0] d;
  } vpdsr_row_t;
  localparam vpdsr_row_t ROWS [10] = '{'{9'h000, 1'b0, 32'h0}, '{9'h07F, 1'b0, 32'h0},
    '{9'h17D, 1'b0, 32'h0}, '{9'h080, 1'b1, 32'h11223344}, '{9'h0A3, 1'b1, 32'h8899AABB},
    '{9'h17C, 1'b1, 32'h0BADF00D}, '{9'h17E, 1'b1, 32'hCAFEF00D},
    '{9'h17F, 1'b1, 32'h01020304}, '{9'h005, 1'b1, 32'hDEADBEEF},
    '{9'h07F, 1'b1, 32'h55667788}};
  logic mclk, rstn, psel, penable, pwrite, srom_miso, pready, pslverr, sl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  vpdsr_pkg::vpdsr_srom_t srom;
  logic [7:0] sh [0:511];
  vpdsr_row_t r;
  int err_count, check_count, w0, e0, nb;
  vpdsr_access #(.WR_CYC(20)) vpdsr_access_inst (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .srom(srom), .srom_miso(srom_miso));
  vpdsr_rom_model vpdsr_rom_model_inst (.cs_n(srom.cs_n), .sck(srom.sck), .mosi(srom.mosi),
    .miso(srom_miso));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one transfer; an idle cycle after it keeps drivers single per step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge mclk);
    if (n == 20) err_count++;
    q = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // poll the flag with a bound instead of assuming a latency
  task automatic poll(input logic f);
    int n;
    n = 0;
    do begin
      apb(`VPDSR_AF_ADDR, 1'b0, 32'h0);
      n++;
    end while (q[15] !== f && n < 3000);
    chk_word(q[15], f);
  endtask
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    for (int i = 0; i < 512; i++) sh[i] = 8'(i) ^ (i[8] ? 8'hC3 : 8'h5A);
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    // table rows: optional write, then a read back of the same place
    for (int i = 0; i < 10; i++) begin
      r = ROWS[i];
      w0 = vpdsr_rom_model_inst.nwr;
      e0 = vpdsr_rom_model_inst.nwe;
      if (r.wr) begin
        nb = (r.a[8:7] == 2'b00) ? 0 : ((9'h180 - r.a) < 4 ? int'(9'h180 - r.a) : 4);
        apb(`VPDSR_DATA_ADDR, 1'b1, r.d);
        apb(`VPDSR_AF_ADDR, 1'b1, {16'h0, 1'b1, 6'h0, r.a});
        apb(`VPDSR_AF_ADDR, 1'b0, 32'h0);
        chk_word(q[15], nb > 0);
        poll(1'b0);
        for (int k = 0; k < nb; k++) sh[9'(r.a + 9'h080 + k)] = r.d[8*k+:8];
        chk_word(vpdsr_rom_model_inst.nwr - w0, nb);
        chk_word(vpdsr_rom_model_inst.nwe - e0, nb > 0);
      end
      apb(`VPDSR_AF_ADDR, 1'b1, {16'h0, 1'b0, 6'h0, r.a});
      apb(`VPDSR_AF_ADDR, 1'b0, 32'h0);
      chk_word(q, {16'h0, 1'b0, 6'h0, r.a});
      poll(1'b1);
      chk_word(q, {16'h0, 1'b1, 6'h0, r.a});
      apb(`VPDSR_DATA_ADDR, 1'b0, 32'h0);
      chk_word(q, {sh[9'(r.a + 9'h083)], sh[9'(r.a + 9'h082)], sh[9'(r.a + 9'h081)],
        sh[9'(r.a + 9'h080)]});
      $display("test %0d done", i);
    end
    // unmapped address is refused and reads zero
    apb(12'h000, 1'b0, 32'h0);
    chk_word(q, 32'h0);
    chk_word(sl, 1'b1);
    $display("unmapped test done");
    // reset in the middle of a read frame
    apb(`VPDSR_AF_ADDR, 1'b1, {16'h0, 1'b0, 6'h0, 9'h010});
    repeat (40) @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    chk_word(srom.cs_n, 1'b1);
    rstn <= 1'b1;
    apb(`VPDSR_AF_ADDR, 1'b0, 32'h0);
    chk_word(q, {16'h0, `VPDSR_AF_RST});
    apb(`VPDSR_DATA_ADDR, 1'b0, 32'h0);
    chk_word(q, `VPDSR_DATA_RST);
    $display("reset test done");
    // partial strobes: only the lanes asked for change
    pstrb <= 4'h3;
    apb(`VPDSR_DATA_ADDR, 1'b1, 32'hA5A5_1234);
    // no strobe on the flag byte: the command is dropped
    pstrb <= 4'h1;
    apb(`VPDSR_AF_ADDR, 1'b1, {16'h0, 1'b0, 6'h0, 9'h010});
    pstrb <= 4'hF;
    apb(`VPDSR_DATA_ADDR, 1'b0, 32'h0);
    chk_word(q, 32'h0000_1234);
    apb(`VPDSR_AF_ADDR, 1'b0, 32'h0);
    chk_word(q, 32'h0000_0000);
    $display("strobe test done");
    tally_and_finish();
  end
endmodule // vpdsr_access_test
`default_nettype wire

// *** tb/vpdsr_rom_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial rom model, spi mode 0, 512 bytes
// ****************************************
module vpdsr_rom_model (
  input wire logic cs_n, // select, low
  input wire logic sck, // rom clock
  input wire logic mosi, // data in
  output logic miso // data out
);
  logic [7:0] mem [0:511];
  logic [31:0] sh;
  logic [7:0] cmd, rd;
  logic [8:0] adr;
  logic wel, dout;
  int cnt, nwr, nwe;
  // fixed pattern, the bench knows it too
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ (i[8] ? 8'hC3 : 8'h5A);
    wel = 1'b0;
    cnt = 0;
    nwr = 0;
    nwe = 0;
    dout = 1'b0;
  end
  // deselected line shows the inverse of its last bit
  assign miso = cs_n ? ~dout : dout;
  always @(negedge cs_n) cnt = 0;
  // the rom itself drops its write latch when a write frame ends
  always @(posedge cs_n) begin
    if (cmd == 8'h02 && cnt > 24) wel = 1'b0;
  end
  // shift in on rising sck; a write needs the latch set first
  always @(posedge sck) begin
    if (!cs_n) begin
      sh = {sh[30:0], mosi};
      cnt = cnt + 1;
      if (cnt == 8) cmd = sh[7:0];
      if (cnt == 8 && sh[7:0] == 8'h06) nwe = nwe + 1;
      if (cnt == 8 && sh[7:0] == 8'h06) wel = 1'b1;
      if (cnt == 24) adr = sh[8:0];
      if (cmd == 8'h02 && cnt > 24 && (cnt - 24) % 8 == 0 && wel) begin
        mem[adr] = sh[7:0];
        adr = adr + 9'h001;
        nwr = nwr + 1;
      end
    end
  end
  // shift out on falling sck, address wraps at the rom end
  always @(negedge sck) begin
    if (!cs_n && cmd == 8'h03 && cnt >= 24) begin
      if ((cnt - 24) % 8 == 0) begin
        rd = mem[adr];
        adr = adr + 9'h001;
      end
      dout = rd[7];
      rd = {rd[6:0], 1'b0};
    end
  end
endmodule // vpdsr_rom_model
`default_nettype wire

// *** verilog/vpdsr_access.sv ***
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "vpdsr_cfg.svh"

// Summary of operation
// - window is last 384 serial rom bytes
// - lowest 128 bytes never written
// - upper 256 bytes readable and writable
// - reads accept addresses 000h to 17Fh
// - read: address low 9, flag 0
// - rom address is byte address plus 080h
// - any byte alignment allowed
// - read done sets flag to 1
// - data byte 0 is addressed byte
// - reads always four bytes, wrapping
// - writes valid for 080h to 17Fh
// - flag 1 starts a rom write
// - write done clears flag to 0
// - bits 8:7 zero: skip, clear flag
// - writes truncated at region end
// - auto write enable when rom disabled
// - auto enable only for this path
// - writes reach only product data region; reads wrap into rom 000h-07Fh
module vpdsr_access #(
  parameter int unsigned WR_CYC = `VPDSR_TWC_NS / `VPDSR_CLK_NS  // rom write cycle wait
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic rstn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic [11:0] paddr, // apb byte address
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // unmapped address
  output vpdsr_pkg::vpdsr_srom_t srom, // rom select, clock, data out
  input wire logic srom_miso // rom data in
);

  // ****************************************
  // state
  // ****************************************
  vpdsr_pkg::vpdsr_state_t st_reg;
  logic [8:0] addr_reg;
  logic flag_reg;
  logic [31:0] data_reg;
  logic [8:0] rom_reg;
  logic [2:0] nb_reg;
  logic op_wr_reg;
  logic wel_reg;
  logic [1:0] ph_reg;
  logic [5:0] cnt_reg;
  logic [55:0] tx_reg;
  logic [31:0] rx_reg;
  logic [20:0] wait_reg;
  logic miso_m_reg;
  logic miso_s_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // ****************************************
  // apb decode
  // ****************************************
  logic acc;
  logic sel_af;
  logic sel_data;
  logic wr_af;
  logic wr_data;
  logic idle;
  logic [8:0] new_addr;
  logic new_flag;
  logic [8:0] new_rom;
  logic wr_reject;
  logic [2:0] new_nb;
  logic bit_end;
  logic frame_end;
  logic rd_done;
  logic [31:0] rx_next;

  assign acc = psel & penable;
  assign sel_af = (paddr == `VPDSR_AF_ADDR);
  assign sel_data = (paddr == `VPDSR_DATA_ADDR);
  assign idle = (st_reg == vpdsr_pkg::ST_IDLE);
  // busy writes are dropped: the engine owns both registers while running
  assign wr_af = acc & pwrite & sel_af & pstrb[1] & idle;
  assign wr_data = acc & pwrite & sel_data & idle;

  // zero-wait slave; read data captured in the setup cycle
  assign pready = acc;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & acc;

  // ****************************************
  // command decode
  // ****************************************
  assign new_addr = pwdata[8:0];
  assign new_flag = pwdata[`VPDSR_AF_FLAG_BIT];
  // 9-bit sum wraps naturally at the rom end
  assign new_rom = 9'(new_addr + `VPDSR_BASE);
  // lower region or past the end never reaches the rom
  assign wr_reject = (new_addr[8:7] == 2'b00) | (new_addr >= `VPDSR_END);
  // bytes left to the region end, at most four
  assign new_nb = (new_addr <= `VPDSR_LAST4) ? 3'h4 : 3'(`VPDSR_END - new_addr);

  // ****************************************
  // bit timing: sck high in phases 2 and 3
  // ****************************************
  assign bit_end = (ph_reg == 2'h3);
  assign frame_end = bit_end & (cnt_reg == 6'h01);
  assign rd_done = frame_end & (st_reg == vpdsr_pkg::ST_XFER) & ~op_wr_reg;
  assign rx_next = {rx_reg[30:0], miso_s_reg};

  // two-flop synchroniser for the rom data pin
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      miso_m_reg <= 1'b0;
      miso_s_reg <= 1'b0;
    end else begin
      miso_m_reg <= srom_miso;
      miso_s_reg <= miso_m_reg;
    end
  end

  // ****************************************
  // apb read path
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel & ~penable) begin
      pslverr_reg <= ~(sel_af | sel_data);
      if (sel_af) begin
        prdata_reg <= {16'h0000, flag_reg, 6'h00, addr_reg};
      end else if (sel_data) begin
        prdata_reg <= data_reg;
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // data register: byte lanes from apb, word from rom
  // ****************************************
  // full-width reset word, so each lane takes only its own byte
  localparam logic [31:0] DATA_RST = `VPDSR_DATA_RST;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          data_reg[gi*8 +: 8] <= DATA_RST[gi*8 +: 8];
        end else if (rd_done) begin
          // first byte on the wire lands in byte 0
          data_reg[gi*8 +: 8] <= rx_next[(3-gi)*8 +: 8];
        end else if (wr_data & pstrb[gi]) begin
          data_reg[gi*8 +: 8] <= pwdata[gi*8 +: 8];
        end
      end
    end
  endgenerate

  // ****************************************
  // control engine
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= vpdsr_pkg::ST_IDLE;
      addr_reg <= 9'h000;
      flag_reg <= 1'b0;
      rom_reg <= 9'h000;
      nb_reg <= 3'h0;
      op_wr_reg <= 1'b0;
      wel_reg <= 1'b0;
      ph_reg <= 2'h0;
      cnt_reg <= 6'h00;
      tx_reg <= 56'h0;
      rx_reg <= 32'h0000_0000;
      wait_reg <= 21'h0;
    end else begin
      unique case (st_reg)
        vpdsr_pkg::ST_IDLE: begin
          ph_reg <= 2'h0;
          if (wr_af) begin
            addr_reg <= new_addr;
            rom_reg <= new_rom;
            nb_reg <= new_nb;
            op_wr_reg <= new_flag;
            if (!new_flag) begin
              // four bytes always, even near the end
              flag_reg <= 1'b0;
              tx_reg <= {`VPDSR_CMD_READ, 7'h00, new_rom, 32'h0};
              cnt_reg <= `VPDSR_RD_BITS;
              st_reg <= vpdsr_pkg::ST_XFER;
            end else if (wr_reject) begin
              flag_reg <= 1'b0;
            end else if (!wel_reg) begin
              // latch not set: enable the rom first
              flag_reg <= 1'b1;
              tx_reg <= {`VPDSR_CMD_WREN, 48'h0};
              cnt_reg <= `VPDSR_WREN_BITS;
              st_reg <= vpdsr_pkg::ST_WREN;
            end else begin
              flag_reg <= 1'b1;
              tx_reg <= {`VPDSR_CMD_WRITE, 7'h00, new_rom, data_reg[7:0], data_reg[15:8],
                         data_reg[23:16], data_reg[31:24]};
              cnt_reg <= 6'(`VPDSR_HDR_BITS + {new_nb, 3'h0});
              st_reg <= vpdsr_pkg::ST_XFER;
            end
          end
        end
        vpdsr_pkg::ST_WREN,
        vpdsr_pkg::ST_XFER: begin
          ph_reg <= ph_reg + 2'h1;
          if (bit_end) begin
            tx_reg <= {tx_reg[54:0], 1'b0};
            rx_reg <= rx_next;
            cnt_reg <= cnt_reg - 6'h01;
          end
          if (frame_end) begin
            if (st_reg == vpdsr_pkg::ST_WREN) begin
              wel_reg <= 1'b1;
              st_reg <= vpdsr_pkg::ST_GAP;
            end else if (op_wr_reg) begin
              // the rom drops its enable latch after a write
              wel_reg <= 1'b0;
              wait_reg <= 21'(WR_CYC);
              st_reg <= vpdsr_pkg::ST_WAIT;
            end else begin
              flag_reg <= 1'b1;
              st_reg <= vpdsr_pkg::ST_IDLE;
            end
          end
        end
        vpdsr_pkg::ST_GAP: begin
          // select stays high for one bit time between frames
          ph_reg <= ph_reg + 2'h1;
          if (bit_end) begin
            tx_reg <= {`VPDSR_CMD_WRITE, 7'h00, rom_reg, data_reg[7:0], data_reg[15:8],
                       data_reg[23:16], data_reg[31:24]};
            cnt_reg <= 6'(`VPDSR_HDR_BITS + {nb_reg, 3'h0});
            st_reg <= vpdsr_pkg::ST_XFER;
          end
        end
        vpdsr_pkg::ST_WAIT: begin
          // no status poll of the rom: fixed worst-case write time
          wait_reg <= wait_reg - 21'h1;
          if (wait_reg <= 21'h1) begin
            flag_reg <= 1'b0;
            st_reg <= vpdsr_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // serial rom pins, registered
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      srom <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
    end else begin
      srom.cs_n <= ~((st_reg == vpdsr_pkg::ST_XFER) | (st_reg == vpdsr_pkg::ST_WREN));
      srom.sck <= ((st_reg == vpdsr_pkg::ST_XFER) | (st_reg == vpdsr_pkg::ST_WREN)) & ph_reg[1];
      srom.mosi <= tx_reg[55];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_wr_start;
    wr_af & new_flag & ~wr_reject;
  endsequence

  sequence s_rd_start;
    wr_af & ~new_flag;
  endsequence

  property p_reject;
    @(posedge mclk) disable iff (!rstn)
      wr_af & new_flag & wr_reject |=> ~flag_reg & (st_reg == vpdsr_pkg::ST_IDLE);
  endproperty
  a_reject: assert property (p_reject) else $error("rejected write not cleared");

  property p_no_low_write;
    @(posedge mclk) disable iff (!rstn)
      (st_reg == vpdsr_pkg::ST_XFER) & op_wr_reg |-> rom_reg >= 9'h100;
  endproperty
  a_no_low_write: assert property (p_no_low_write) else $error("write to read-only area");

  property p_base;
    logic [8:0] a;
    @(posedge mclk) disable iff (!rstn)
      (wr_af, a = new_addr) |=> rom_reg == 9'(a + 9'h080);
  endproperty
  a_base: assert property (p_base) else $error("rom address not based");

  property p_read4;
    @(posedge mclk) disable iff (!rstn)
      s_rd_start |=> (cnt_reg == 6'h38) & (st_reg == vpdsr_pkg::ST_XFER);
  endproperty
  a_read4: assert property (p_read4) else $error("read not four bytes");

  property p_rd_hold;
    @(posedge mclk) disable iff (!rstn)
      s_rd_start |=> ~flag_reg throughout (st_reg == vpdsr_pkg::ST_XFER)[*8];
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("flag moved during read");

  property p_rd_done;
    @(posedge mclk) disable iff (!rstn)
      rd_done |=> flag_reg & idle & (data_reg[7:0] == $past(rx_next[31:24]));
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read result wrong");

  property p_wren;
    @(posedge mclk) disable iff (!rstn)
      s_wr_start & ~wel_reg |=> (st_reg == vpdsr_pkg::ST_WREN) & flag_reg;
  endproperty
  a_wren: assert property (p_wren) else $error("missing write enable");

  property p_trunc;
    @(posedge mclk) disable iff (!rstn)
      (st_reg == vpdsr_pkg::ST_GAP) & bit_end & (addr_reg == 9'h17F) |=> cnt_reg == 6'h20;
  endproperty
  a_trunc: assert property (p_trunc) else $error("tail write not truncated");

  property p_wr_done;
    @(posedge mclk) disable iff (!rstn)
      (st_reg == vpdsr_pkg::ST_WAIT) & (wait_reg == 21'h1) |=> ~flag_reg ##0 idle;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write flag not cleared");

  property p_wr_hold;
    @(posedge mclk) disable iff (!rstn)
      (st_reg == vpdsr_pkg::ST_WAIT) |-> flag_reg;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("flag dropped early");

  // flag moves only where an operation starts or ends
  property p_flag_stable;
    @(posedge mclk) disable iff (!rstn)
      ~idle & ~frame_end & ~((st_reg == vpdsr_pkg::ST_WAIT) & (wait_reg <= 21'h1))
        |=> $stable(flag_reg);
  endproperty
  a_flag_stable: assert property (p_flag_stable) else $error("flag changed mid operation");

  property p_unmapped;
    @(posedge mclk) disable iff (!rstn)
      psel & ~penable & ~(sel_af | sel_data) |=> pslverr_reg & (prdata_reg == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_wr_range;
    @(posedge mclk) disable iff (!rstn)
      (st_reg == vpdsr_pkg::ST_XFER) & op_wr_reg |-> (addr_reg >= 9'h080) & (addr_reg < 9'h180);
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("write outside writable range");

  // the enable frame must be closed before the write frame opens
  property p_gap;
    @(posedge mclk) disable iff (!rstn)
      (st_reg == vpdsr_pkg::ST_WREN) & frame_end |=> ##1 srom.cs_n;
  endproperty
  a_gap: assert property (p_gap) else $error("no deselect after write enable");

endmodule // vpdsr_access
`default_nettype wire

// *** verilog/vpdsr_cfg.svh ***
`ifndef VPDSR_CFG_SVH
`define VPDSR_CFG_SVH
// ****************************************
// register map (byte address = 4 * index)
// ****************************************
`define VPDSR_AF_IDX 12'h0E6
`define VPDSR_DATA_IDX 12'h0E8
`define VPDSR_AF_ADDR 12'h398
`define VPDSR_DATA_ADDR 12'h3A0
// address/flag fields and reset values
`define VPDSR_AF_FLAG_BIT 15
`define VPDSR_AF_ADDR_W 9
`define VPDSR_AF_RST 16'h0000
`define VPDSR_DATA_RST 32'h0000_0000
// ****************************************
// product data region
// ****************************************
`define VPDSR_BASE 9'h080
`define VPDSR_END 9'h180
`define VPDSR_LAST4 9'h17C
// ****************************************
// serial rom commands and timing
// ****************************************
`define VPDSR_CMD_READ 8'h03
`define VPDSR_CMD_WRITE 8'h02
`define VPDSR_CMD_WREN 8'h06
`define VPDSR_CLK_NS 4
`define VPDSR_TWC_NS 5000000
`define VPDSR_RD_BITS 6'h38
`define VPDSR_HDR_BITS 6'h18
`define VPDSR_WREN_BITS 6'h08
`endif

// *** verilog/vpdsr_pkg.sv ***
`default_nettype none
package vpdsr_pkg;
  // engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WREN,
    ST_GAP,
    ST_XFER,
    ST_WAIT
  } vpdsr_state_t;
  // serial rom output pins, kept together
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } vpdsr_srom_t;
endpackage
`default_nettype wire
